// >>> logic/pfcd_top.sv
// Program-flash command decoder and dispatcher with register port and interrupt.
// Assumes an array engine on the same clock answering OP_START with one OP_DONE pulse.
`include "pfcd_defines.svh"
module pfcd_top
	import pfcd_pkg::*;
(
	input  wire logic        CLK,          // 100 MHz clock
	input  wire logic        ARST_N,       // Async reset, active low
	input  wire logic [7:0]  ADDR,         // Register address
	input  wire logic [31:0] WDATA,        // Write data
	input  wire logic        WR,           // Write strobe
	input  wire logic        RD,           // Read strobe
	output logic      [31:0] RDATA,        // Read data, cycle after RD
	input  wire logic        SS_MODE,      // Special single-chip pin
	input  wire logic        SECURE,       // Secured-state pin
	output logic             OP_START,     // Array operation start pulse
	output logic      [7:0]  OP_CODE,      // Operation code
	output logic      [31:0] OP_P0,        // Address or selector
	output logic      [31:0] OP_P1,        // Data, count or key
	input  wire logic        OP_DONE,      // Array operation done pulse
	input  wire logic        OP_FAIL,      // Failure beside OP_DONE
	input  wire logic [31:0] OP_RDATA,     // Result beside OP_DONE
	output logic      [5:0]  CLK_DIV,      // Divider value
	output logic      [1:0]  MARGIN_LEVEL, // Applied margin level
	output logic             SEC_RELEASE,  // Security released
	output logic             IRQ           // Interrupt, level
);
	////////////////////////////////////////////////////////////////////
	// Pin synchronisers
	logic [1:0] pin_in;
	logic [1:0] s1, s2, s3, pin_q;
	assign pin_in = {SECURE, SS_MODE};

	genvar g;
	generate
		for (g = 0; g < 2; g++) begin : g_sync
			// Three flops; value moves when the last two agree
			always_ff @(posedge CLK or negedge ARST_N) begin
				if (!ARST_N) begin
					s1[g]    <= 1'b0;
					s2[g]    <= 1'b0;
					s3[g]    <= 1'b0;
					pin_q[g] <= 1'b0;
				end else begin
					s1[g] <= pin_in[g];
					s2[g] <= s1[g];
					s3[g] <= s2[g];
					if (s2[g] == s3[g])
						pin_q[g] <= s3[g];
				end
			end
		end
	endgenerate

	////////////////////////////////////////////////////////////////////
	// Registers and state
	pfcd_state_t state;
	logic [7:0]  cmd;
	logic [31:0] param0, param1, result;
	logic        div_loaded, lo_dis, hi_dis, p_open, e_open;
	logic        done_flag, acc_err, pviol;
	logic [1:0]  istat, imask;
	logic [7:0]  once_used;
	logic        idle, legal, prog_erase;

	assign idle = (state == PFCD_IDLE);

	// Mode-dependent permission decode
	pfcd_decode u_dec (
		.code       (cmd),
		.ss_mode    (pin_q[0]),
		.secured    (pin_q[1]),
		.legal      (legal),
		.prog_erase (prog_erase)
	);

	////////////////////////////////////////////////////////////////////
	// Launch checks
	logic       wr_stat, launch_req, err_acc, err_prot, go;
	logic       once_hit, all_open;
	logic [2:0] once_idx;

	assign wr_stat    = WR && (ADDR == `PFCD_OFS_STAT);
	assign launch_req = wr_stat && WDATA[`PFCD_STAT_DONE] && done_flag
		&& !acc_err && !pviol;
	assign once_idx   = param0[2:0];
	assign once_hit   = (cmd == `PFCD_C_PONCE) && once_used[once_idx];
	assign all_open   = lo_dis && hi_dis && p_open;
	assign err_acc    = !legal
		|| (prog_erase && !div_loaded)
		|| once_hit;
	// Protection gating of the mass erases
	always_comb begin
		err_prot = 1'b0;
		if (cmd == `PFCD_C_ERALL)
			err_prot = !(all_open && e_open);
		else if (cmd == `PFCD_C_ERBLK)
			err_prot = param0[`PFCD_SEL_EE] ? !e_open : !all_open;
	end
	assign go = launch_req && !err_acc && !err_prot;

	////////////////////////////////////////////////////////////////////
	// Sequencer
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			state <= PFCD_IDLE;
		end else begin
			case (state)
				PFCD_IDLE: if (go) state <= PFCD_BUSY;
				PFCD_BUSY: if (OP_DONE) state <= PFCD_IDLE;
				default:   state <= PFCD_IDLE;
			endcase
		end
	end

	// Dispatch to the array engine; code selects the operation
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			OP_START <= 1'b0;
			OP_CODE  <= `PFCD_RST_CMD;
			OP_P0    <= `PFCD_RST_WORD;
			OP_P1    <= `PFCD_RST_WORD;
		end else begin
			OP_START <= go;
			if (go) begin
				OP_CODE <= cmd;
				OP_P0   <= param0;
				OP_P1   <= param1;
			end
		end
	end

	// Complete flag: low from launch to done
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N)
			done_flag <= 1'b1;
		else if (go)
			done_flag <= 1'b0;
		else if (!idle && OP_DONE)
			done_flag <= 1'b1;
	end

	// Error flags: write one clears, a new error wins
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			acc_err <= 1'b0;
			pviol   <= 1'b0;
		end else begin
			if (launch_req && err_acc)
				acc_err <= 1'b1;
			else if (wr_stat && WDATA[`PFCD_STAT_ACC])
				acc_err <= 1'b0;
			if (launch_req && !err_acc && err_prot)
				pviol <= 1'b1;
			else if (wr_stat && WDATA[`PFCD_STAT_PVIOL])
				pviol <= 1'b0;
		end
	end

	// Completion effects: result, one-time parts, margin, security
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			result       <= `PFCD_RST_WORD;
			once_used    <= 8'h00;
			MARGIN_LEVEL <= 2'h0;
			SEC_RELEASE  <= 1'b0;
		end else if (!idle && OP_DONE) begin
			result <= OP_RDATA;
			if (!OP_FAIL) begin
				if (OP_CODE == `PFCD_C_PONCE)
					once_used[OP_P0[2:0]] <= 1'b1;
				if (OP_CODE == `PFCD_C_UMARG || OP_CODE == `PFCD_C_FMARG)
					MARGIN_LEVEL <= OP_P1[1:0];
				if (OP_CODE == `PFCD_C_UNSEC || OP_CODE == `PFCD_C_KEY)
					SEC_RELEASE <= 1'b1;
			end
		end
	end

	////////////////////////////////////////////////////////////////////
	// Software-written registers; command buffer ignored while busy
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			cmd    <= `PFCD_RST_CMD;
			param0 <= `PFCD_RST_WORD;
			param1 <= `PFCD_RST_WORD;
		end else if (WR && done_flag) begin
			case (ADDR)
				`PFCD_OFS_CMD:    cmd    <= WDATA[7:0];
				`PFCD_OFS_PARAM0: param0 <= WDATA;
				`PFCD_OFS_PARAM1: param1 <= WDATA;
				default:          cmd    <= cmd;
			endcase
		end
	end

	// Divider and protection; a divider write while idle marks it loaded
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			CLK_DIV    <= `PFCD_RST_DIV;
			div_loaded <= 1'b0;
			lo_dis     <= 1'b0;
			hi_dis     <= 1'b0;
			p_open     <= 1'b0;
			e_open     <= 1'b0;
		end else if (WR) begin
			if (ADDR == `PFCD_OFS_CLKDIV && idle) begin
				CLK_DIV    <= WDATA[5:0];
				div_loaded <= 1'b1;
			end
			if (ADDR == `PFCD_OFS_PPROT) begin
				lo_dis <= WDATA[`PFCD_PROT_LO];
				hi_dis <= WDATA[`PFCD_PROT_HI];
				p_open <= WDATA[`PFCD_PROT_OPEN];
			end
			if (ADDR == `PFCD_OFS_EPROT)
				e_open <= WDATA[`PFCD_EPROT_OPEN];
		end
	end

	////////////////////////////////////////////////////////////////////
	// Interrupt status, cleared by read; events win over the clear
	logic [1:0] ev;
	assign ev = {launch_req && (err_acc || err_prot), !idle && OP_DONE};

	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			istat <= 2'h0;
			imask <= 2'h0;
			IRQ   <= 1'b0;
		end else begin
			if (RD && ADDR == `PFCD_OFS_ISTAT)
				istat <= ev;
			else
				istat <= istat | ev;
			if (WR && ADDR == `PFCD_OFS_IMASK)
				imask <= WDATA[1:0];
			IRQ <= |(istat & imask);
		end
	end

	// Read mux, data in the cycle after the strobe
	always_ff @(posedge CLK or negedge ARST_N) begin
		if (!ARST_N) begin
			RDATA <= `PFCD_RST_WORD;
		end else if (RD) begin
			case (ADDR)
				`PFCD_OFS_CMD:    RDATA <= {24'h000000, cmd};
				`PFCD_OFS_PARAM0: RDATA <= param0;
				`PFCD_OFS_PARAM1: RDATA <= param1;
				`PFCD_OFS_CLKDIV: RDATA <= {24'h000000, div_loaded, 1'b0, CLK_DIV};
				`PFCD_OFS_PPROT:  RDATA <= {29'h00000000, p_open, hi_dis, lo_dis};
				`PFCD_OFS_EPROT:  RDATA <= {31'h00000000, e_open};
				`PFCD_OFS_STAT:   RDATA <= {24'h000000, done_flag, 1'b0, acc_err,
					pviol, 4'h0};
				`PFCD_OFS_ISTAT:  RDATA <= {30'h00000000, istat};
				`PFCD_OFS_IMASK:  RDATA <= {30'h00000000, imask};
				`PFCD_OFS_RESULT: RDATA <= result;
				`PFCD_OFS_STATE:  RDATA <= {20'h00000, once_used, SEC_RELEASE,
					pin_q[1], pin_q[0], state == PFCD_BUSY};
				default:          RDATA <= `PFCD_RST_WORD;
			endcase
		end else begin
			RDATA <= `PFCD_RST_WORD;
		end
	end

	////////////////////////////////////////////////////////////////////
	// Assertions
	a_launch_starts: assert property (@(posedge CLK) disable iff (!ARST_N)
		go |=> OP_START && !done_flag)
		else $error("launch did not start operation");
	a_flag_stays_low: assert property (@(posedge CLK) disable iff (!ARST_N)
		!done_flag && !OP_DONE |=> !done_flag)
		else $error("complete flag rose early");
	a_flag_rises: assert property (@(posedge CLK) disable iff (!ARST_N)
		!idle && OP_DONE |=> done_flag && idle)
		else $error("complete flag not raised");
	a_div_needed: assert property (@(posedge CLK) disable iff (!ARST_N)
		launch_req && prog_erase && !div_loaded |=> acc_err && !OP_START)
		else $error("undivided program or erase ran");
	a_bad_code: assert property (@(posedge CLK) disable iff (!ARST_N)
		launch_req && cmd == 8'h05 |=> acc_err && done_flag)
		else $error("unknown code not refused");
	a_mass_guard: assert property (@(posedge CLK) disable iff (!ARST_N)
		OP_START && OP_CODE == `PFCD_C_ERALL |-> $past(all_open && e_open))
		else $error("array erase without open bits");
	a_block_guard: assert property (@(posedge CLK) disable iff (!ARST_N)
		OP_START && OP_CODE == `PFCD_C_ERBLK && !OP_P0[`PFCD_SEL_EE] |-> $past(all_open))
		else $error("block erase without open bits");
	a_once_only: assert property (@(posedge CLK) disable iff (!ARST_N)
		OP_START && OP_CODE == `PFCD_C_PONCE |-> !once_used[OP_P0[2:0]])
		else $error("one-time part programmed twice");
	a_field_margin: assert property (@(posedge CLK) disable iff (!ARST_N)
		OP_START && OP_CODE == `PFCD_C_FMARG |-> $past(pin_q[0] && !pin_q[1]))
		else $error("field margin outside special mode");
	a_key_mode: assert property (@(posedge CLK) disable iff (!ARST_N)
		OP_START && OP_CODE == `PFCD_C_KEY |-> $past(!pin_q[0]))
		else $error("key verify in special mode");
	a_release: assert property (@(posedge CLK) disable iff (!ARST_N)
		!idle && OP_DONE && !OP_FAIL && OP_CODE == `PFCD_C_UNSEC |=> SEC_RELEASE)
		else $error("security not released");
	c_launch_done: cover property (@(posedge CLK) disable iff (!ARST_N)
		go ##[1:50] OP_DONE);
	c_acc_err: cover property (@(posedge CLK) disable iff (!ARST_N)
		launch_req && err_acc);
	c_prot_err: cover property (@(posedge CLK) disable iff (!ARST_N)
		launch_req && !err_acc && err_prot);
	a_busy_no_load: assert property (@(posedge CLK) disable iff (!ARST_N)
		!done_flag && WR && ADDR == `PFCD_OFS_CMD |=> cmd == $past(cmd))
		else $error("command loaded while busy");
	a_refused_idle: assert property (@(posedge CLK) disable iff (!ARST_N)
		launch_req && (err_acc || err_prot) |=> !OP_START && done_flag && idle)
		else $error("refused command started");
	a_once_mark: assert property (@(posedge CLK) disable iff (!ARST_N)
		!idle && OP_DONE && !OP_FAIL && OP_CODE == `PFCD_C_PONCE
		|=> once_used[$past(OP_P0[2:0])])
		else $error("one-time part not marked");
	c_once_refused: cover property (@(posedge CLK) disable iff (!ARST_N)
		launch_req && once_hit);
	c_irq_raise: cover property (@(posedge CLK) disable iff (!ARST_N)
		!IRQ ##1 IRQ);
endmodule

// >>> logic/pfcd_defines.svh
// Offsets, field positions, reset values and command codes of the command decoder.
// Assumes inclusion by bare name from files under logic/.
`ifndef PFCD_DEFINES_SVH
`define PFCD_DEFINES_SVH

// Register offsets on the plain register port
`define PFCD_OFS_CMD     8'h00
`define PFCD_OFS_PARAM0  8'h04
`define PFCD_OFS_PARAM1  8'h08
`define PFCD_OFS_CLKDIV  8'h0C
`define PFCD_OFS_PPROT   8'h10
`define PFCD_OFS_EPROT   8'h14
`define PFCD_OFS_STAT    8'h18
`define PFCD_OFS_ISTAT   8'h1C
`define PFCD_OFS_IMASK   8'h20
`define PFCD_OFS_RESULT  8'h24
`define PFCD_OFS_STATE   8'h28

// Field positions
`define PFCD_STAT_DONE   7
`define PFCD_STAT_ACC    5
`define PFCD_STAT_PVIOL  4
`define PFCD_DIV_LOADED  7
`define PFCD_PROT_LO     0
`define PFCD_PROT_HI     1
`define PFCD_PROT_OPEN   2
`define PFCD_EPROT_OPEN  0
`define PFCD_SEL_EE      31
`define PFCD_INT_DONE    0
`define PFCD_INT_ERR     1

// Reset values
`define PFCD_RST_CMD     8'h00
`define PFCD_RST_DIV     6'h00
`define PFCD_RST_WORD    32'h0000_0000

// Command codes
`define PFCD_C_EVALL     8'h01
`define PFCD_C_EVBLK     8'h02
`define PFCD_C_EVSEC     8'h03
`define PFCD_C_RDONCE    8'h04
`define PFCD_C_PROG      8'h06
`define PFCD_C_PONCE     8'h07
`define PFCD_C_ERALL     8'h08
`define PFCD_C_ERBLK     8'h09
`define PFCD_C_ERSEC     8'h0A
`define PFCD_C_UNSEC     8'h0B
`define PFCD_C_KEY       8'h0C
`define PFCD_C_UMARG     8'h0D
`define PFCD_C_FMARG     8'h0E

// One-time field: 64 bytes as eight 8-byte parts
`define PFCD_ONCE_PARTS  8
`endif

// >>> logic/pfcd_pkg.sv
// Types of the program-flash command decoder.
// Assumes nothing beyond a SystemVerilog compiler.
package pfcd_pkg;
	// Sequencer states, one-hot
	typedef enum logic [1:0] {
		PFCD_IDLE = 2'b01,
		PFCD_BUSY = 2'b10
	} pfcd_state_t;
endpackage

// >>> logic/pfcd_decode.sv
// Command legality decoder: permitted codes per mode and security state.
// Assumes synchronised mode and security levels on the same clock.
`include "pfcd_defines.svh"
module pfcd_decode
	import pfcd_pkg::*;
(
	input  wire logic [7:0] code,       // Loaded command code
	input  wire logic       ss_mode,    // Special single-chip mode
	input  wire logic       secured,    // Chip secured
	output logic            legal,      // Code allowed now
	output logic            prog_erase  // Code programs or erases
);
	// Permission table by mode and security
	always_comb begin
		legal = 1'b0;
		case (code)
			`PFCD_C_EVALL, `PFCD_C_EVBLK: legal = 1'b1;
			`PFCD_C_EVSEC, `PFCD_C_RDONCE, `PFCD_C_PROG, `PFCD_C_PONCE,
			`PFCD_C_ERBLK, `PFCD_C_ERSEC, `PFCD_C_UMARG:
				legal = !(ss_mode && secured);
			`PFCD_C_ERALL, `PFCD_C_UNSEC: legal = ss_mode;
			`PFCD_C_KEY:   legal = !ss_mode;
			`PFCD_C_FMARG: legal = ss_mode && !secured;
			default:       legal = 1'b0;
		endcase
	end

	// Commands needing the divider to be loaded
	always_comb begin
		case (code)
			`PFCD_C_PROG, `PFCD_C_PONCE, `PFCD_C_ERALL, `PFCD_C_ERBLK,
			`PFCD_C_ERSEC, `PFCD_C_UNSEC: prog_erase = 1'b1;
			default: prog_erase = 1'b0;
		endcase
	end
endmodule

// >>> verif/test_pfcd_top.sv
// Self-checking bench for the program-flash command decoder.
// Assumes the bench plays the array engine by hand on OP_DONE.
`include "pfcd_defines.svh"
module test_pfcd_top
	import pfcd_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ps;

	logic        clk = 1'b0;
	logic        arst_n = 1'b0;
	logic [7:0]  addr = 8'h00;
	logic [31:0] wdata = 32'h0;
	logic        wr = 1'b0;
	logic        rd = 1'b0;
	logic [31:0] rdata;
	logic        ss_mode = 1'b0;
	logic        secure = 1'b0;
	logic        op_start;
	logic [7:0]  op_code;
	logic [31:0] op_p0;
	logic [31:0] op_p1;
	logic        op_done = 1'b0;
	logic        op_fail = 1'b0;
	logic [31:0] op_rdata = 32'h0;
	logic [5:0]  clk_div;
	logic [1:0]  margin_level;
	logic        sec_release;
	logic        irq;
	int          failures = 0;
	int          n_checks = 0;
	logic [31:0] v;
	logic        fail_next = 1'b0;
	logic [7:0]  ns_ok [10] = '{8'h01, 8'h02, 8'h03, 8'h04, 8'h06, 8'h07, 8'h09, 8'h0A,
		8'h0C, 8'h0D};
	logic [7:0]  ns_no [3] = '{8'h08, 8'h0B, 8'h0E};

	////////////////////////////////////////////////////////////////
	// Clock and device
	always #5 clk = ~clk;

	pfcd_top u_dut (
		.CLK(clk), .ARST_N(arst_n), .ADDR(addr), .WDATA(wdata), .WR(wr), .RD(rd),
		.RDATA(rdata), .SS_MODE(ss_mode), .SECURE(secure), .OP_START(op_start),
		.OP_CODE(op_code), .OP_P0(op_p0), .OP_P1(op_p1), .OP_DONE(op_done),
		.OP_FAIL(op_fail), .OP_RDATA(op_rdata), .CLK_DIV(clk_div),
		.MARGIN_LEVEL(margin_level), .SEC_RELEASE(sec_release), .IRQ(irq)
	);

	////////////////////////////////////////////////////////////////
	// Bus and compare tasks
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		n_checks++;
		if (got !== exp) begin
			failures++;
			$display("Error %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wrr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		addr <= a;
		rd <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		v = rdata;
	endtask

	// Engine answer: one done pulse carrying a result word
	task automatic done(input logic [31:0] d);
		repeat (2) @(posedge clk);
		op_done <= 1'b1;
		op_fail <= fail_next;
		op_rdata <= d;
		@(posedge clk);
		op_done <= 1'b0;
		op_fail <= 1'b0;
	endtask

	// Load and launch; kind 0 accepted, 1 access error, 2 protection violation
	task automatic try(input logic [7:0] c, input logic [31:0] p0, input int kind);
		wrr(`PFCD_OFS_CMD, {24'h0, c});
		wrr(`PFCD_OFS_PARAM0, p0);
		wrr(`PFCD_OFS_PARAM1, 32'h2);
		wrr(`PFCD_OFS_STAT, 32'h80);
		#1;
		chk("start", {31'h0, kind == 0}, {31'h0, op_start});
		if (kind == 0) begin
			chk("op code", {24'h0, c}, {24'h0, op_code});
			chk("op p0", p0, op_p0);
			chk("op p1", 32'h2, op_p1);
			rdr(`PFCD_OFS_STAT);
			chk("busy stat", 32'h00, {24'h0, v[7:0]});
			done({24'hA5A5A5, c});
			rdr(`PFCD_OFS_RESULT);
			chk("result", {24'hA5A5A5, c}, v);
		end
		rdr(`PFCD_OFS_STAT);
		chk("stat", (kind == 0) ? 32'h80 : (kind == 1) ? 32'hA0 : 32'h90, {24'h0, v[7:0]});
		if (kind != 0)
			wrr(`PFCD_OFS_STAT, 32'h30);
	endtask

	task automatic finish_test();
		$display("Comparisons %0d mismatches %0d", n_checks, failures);
		if (failures == 0 && n_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Watchdog
	initial begin
		#300us;
		failures++;
		$display("Error watchdog expired");
		finish_test();
	end

	////////////////////////////////////////////////////////////////
	// Test sequence
	initial begin
		repeat (16) @(posedge clk);
		arst_n <= 1'b1;
		rdr(`PFCD_OFS_STAT);
		chk("reset stat", 32'h80, {24'h0, v[7:0]});
		rdr(8'h30);
		chk("unmapped", 32'h0, v);
		try(8'h06, 32'h0, 1);
		try(8'h01, 32'h0, 0);
		wrr(`PFCD_OFS_CLKDIV, 32'h05);
		rdr(`PFCD_OFS_CLKDIV);
		chk("divider", 32'h85, v);
		chk("clk div", 32'h05, {26'h0, clk_div});
		try(8'h05, 32'h0, 1);
		try(8'h10, 32'h0, 1);
		wrr(`PFCD_OFS_PPROT, 32'h3);
		try(8'h09, 32'h0, 2);
		wrr(`PFCD_OFS_PPROT, 32'h7);
		try(8'h09, 32'h8000_0000, 2);
		wrr(`PFCD_OFS_EPROT, 32'h1);
		try(8'h09, 32'h8000_0000, 0);
		chk("sec idle", 32'h0, {31'h0, sec_release});
		// Normal unsecured: permitted then refused codes
		foreach (ns_ok[i])
			try(ns_ok[i], 32'h3, 0);
		foreach (ns_no[i])
			try(ns_no[i], 32'h3, 1);
		chk("sec release", 32'h1, {31'h0, sec_release});
		chk("margin", 32'h2, {30'h0, margin_level});
		try(8'h07, 32'h3, 1);
		try(8'h07, 32'h4, 0);
		// A failed one-time write leaves its part usable
		fail_next = 1'b1;
		try(8'h07, 32'h5, 0);
		fail_next = 1'b0;
		try(8'h07, 32'h5, 0);
		rdr(`PFCD_OFS_STATE);
		chk("state", 32'h388, v);
		// Writes and launches while busy are ignored
		wrr(`PFCD_OFS_CMD, 32'h06);
		wrr(`PFCD_OFS_STAT, 32'h80);
		wrr(`PFCD_OFS_CMD, 32'h0A);
		wrr(`PFCD_OFS_STAT, 32'h80);
		#1;
		chk("busy start", 32'h0, {31'h0, op_start});
		done(32'h0);
		rdr(`PFCD_OFS_CMD);
		chk("busy cmd", 32'h06, {24'h0, v[7:0]});
		// Interrupt raise, clear, mask
		rdr(`PFCD_OFS_ISTAT);
		wrr(`PFCD_OFS_IMASK, 32'h1);
		try(8'h01, 32'h0, 0);
		chk("irq done", 32'h1, {31'h0, irq});
		rdr(`PFCD_OFS_ISTAT);
		chk("istat done", 32'h1, v);
		repeat (2) @(posedge clk);
		chk("irq clear", 32'h0, {31'h0, irq});
		wrr(`PFCD_OFS_IMASK, 32'h0);
		try(8'h05, 32'h0, 1);
		chk("irq masked", 32'h0, {31'h0, irq});
		wrr(`PFCD_OFS_IMASK, 32'h2);
		repeat (2) @(posedge clk);
		chk("irq err", 32'h1, {31'h0, irq});
		rdr(`PFCD_OFS_ISTAT);
		chk("istat err", 32'h2, v);
		// Special single-chip, unsecured
		@(posedge clk);
		ss_mode <= 1'b1;
		repeat (5) @(posedge clk);
		try(8'h0E, 32'h0, 0);
		try(8'h0C, 32'h0, 1);
		wrr(`PFCD_OFS_EPROT, 32'h0);
		try(8'h08, 32'h0, 2);
		wrr(`PFCD_OFS_EPROT, 32'h1);
		try(8'h08, 32'h0, 0);
		// Special single-chip, secured
		@(posedge clk);
		secure <= 1'b1;
		repeat (5) @(posedge clk);
		try(8'h0B, 32'h0, 0);
		try(8'h03, 32'h0, 1);
		try(8'h02, 32'h0, 0);
		finish_test();
	end
endmodule
